/* interrupt_vector_selector_test.sv */
// Purpose: self-checking bench for the vector selector
// Assumes: AXI4-Lite master tasks, CPU fetch model
// Notes:   table rows first, awkward cases after
`timescale 1ns/1ps
`include "ivs_params.svh"
module interrupt_vector_selector_test;
	typedef struct packed {
		logic        trap;
		logic [6:0]  num;
		logic        alt;
		logic [23:0] addr;
	} ivs_row_s;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, done, irq, go = 1'h0, trap = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] src_event = 16'h0;
	logic [6:0]  num = 7'h00;
	logic [3:0]  lag = 4'h0;
	logic [23:0] reset_pc;
	int          failures = 0, n_checks = 0, cycles = 0;
	ivs_pkg::ivs_fetch_req_s req;
	ivs_pkg::ivs_fetch_rsp_s rsp;
	ivs_row_s    rows [9] = '{
		'{1'h1, 7'h07, 1'h0, 24'h000012},
		'{1'h1, 7'h01, 1'h0, 24'h000006}, '{1'h1, 7'h04, 1'h1, 24'h00010C},
		'{1'h1, 7'h07, 1'h1, 24'h000112}, '{1'h0, 7'h00, 1'h0, 24'h000014},
		'{1'h0, 7'h03, 1'h0, 24'h00001A}, '{1'h0, 7'h03, 1'h1, 24'h00011A},
		'{1'h0, 7'h0D, 1'h1, 24'h00012E}, '{1'h0, 7'h0F, 1'h0, 24'h000032}};
	ivs_vector_selector dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.src_event(src_event), .fetch_req(req), .fetch_done(done), .fetch_rsp(rsp),
		.reset_pc(reset_pc), .irq(irq));
	ivs_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn), .go(go), .trap(trap), .num(num),
		.lag(lag), .rsp(rsp), .req(req), .done(done));
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Ready is looked at mid-cycle, so the handshake edge is the next rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end while (!tb);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tb;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tb = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'h0;
		end while (!tb);
		rready <= 1'h0;
	endtask
	task automatic fetch(input logic t, input logic [6:0] n, input logic [3:0] l);
		@(posedge aclk);
		trap <= t;
		num <= n;
		lag <= l;
		go <= 1'h1;
		@(posedge aclk);
		go <= 1'h0;
		do @(negedge aclk); while (!rsp.valid);
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		chk("reset_pc", {8'h00, reset_pc}, 32'h0);
		chk("rsp_valid", {31'h0, rsp.valid}, 32'h0);
		foreach (rows[i]) begin
			wr(`IVS_OFF_CTRL2, {16'h0, rows[i].alt, 15'h0});
			fetch(rows[i].trap, rows[i].num, 4'h0);
			chk("vec_addr", {8'h00, rsp.addr}, {8'h00, rows[i].addr});
			chk("vec_alt", {31'h0, rsp.alt}, {31'h0, rows[i].alt});
			do @(negedge aclk); while (rsp.valid);
		end
		wr(`IVS_OFF_CTRL2, 32'h0);
		fetch(1'h0, 7'h03, 4'hF);
		wr(`IVS_OFF_CTRL2, 32'h0000_8000);
		@(negedge aclk);
		chk("held_vec", {7'h00, rsp.valid, rsp.addr}, 32'h0100_001A);
		do @(negedge aclk); while (rsp.valid);
		rd(`IVS_OFF_CTRL2);
		chk("ctrl2", d, 32'h0000_8000);
		wr(`IVS_OFF_EN0, 32'h0000_0028);
		wr(`IVS_OFF_PRIO0, 32'h0030_3000);
		rd(`IVS_OFF_PRIO0);
		chk("prio0", d, 32'h0030_3000);
		@(posedge aclk);
		src_event <= 16'h0028;
		@(posedge aclk);
		src_event <= 16'h0000;
		rd(`IVS_OFF_REQ0);
		chk("req0", d, 32'h0000_0028);
		rd(`IVS_OFF_VECSTAT);
		chk("winner", d & 32'h0000_01FF, 32'h0000_0103);
		wr(`IVS_OFF_IRQMASK, 32'h0);
		wr(`IVS_OFF_IRQSTAT, 32'h3);
		fetch(1'h0, 7'h05, 4'h2);
		do @(negedge aclk); while (rsp.valid);
		rd(`IVS_OFF_IRQSTAT);
		chk("fetch_taken", d & 32'h2, 32'h2);
		@(negedge aclk);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(`IVS_OFF_IRQMASK, 32'h2);
		@(negedge aclk);
		chk("irq_on", {31'h0, irq}, 32'h1);
		wr(`IVS_OFF_IRQSTAT, 32'h2);
		@(negedge aclk);
		chk("irq_off", {31'h0, irq}, 32'h0);
		rd(8'h40);
		chk("bad_rresp", {30'h0, r}, 32'h2);
		chk("bad_rdata", d, 32'h0);
		wr(8'h40, 32'hFFFF_FFFF);
		chk("bad_bresp", {30'h0, r}, 32'h2);
		// Second reset mid-run must wipe the table select
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`IVS_OFF_CTRL2);
		chk("ctrl2_rst", d, 32'h0);
		fetch(1'h1, 7'h02, 4'h0);
		chk("vec_after_rst", {8'h00, rsp.addr}, 32'h0000_0008);
		test_done();
	end
endmodule // interrupt_vector_selector_test

/* ivs_cpu_model.sv */
// Purpose: CPU-side vector fetch partner
// Assumes: answer is registered and stands until done
// Notes:   a released number bus shows the inverse value
`timescale 1ns/1ps
module ivs_cpu_model (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    go,
	input  wire logic                    trap,
	input  wire logic [6:0]              num,
	input  wire logic [3:0]              lag,
	input  wire ivs_pkg::ivs_fetch_rsp_s rsp,
	output ivs_pkg::ivs_fetch_req_s      req,
	output logic                         done
);
	logic [3:0] cnt_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req <= '0;
			done <= 1'h0;
			cnt_q <= 4'h0;
		end else begin
			done <= 1'h0;
			if (go)
				req <= '{1'h1, trap, num};
			else if (req.valid && rsp.valid)
				req <= '{1'h0, req.is_trap, ~req.number};
			// Slow CPU: hold the vector lag cycles
			if (rsp.valid && !req.valid && !done) begin
				if (cnt_q == lag) begin
					done <= 1'h1;
					cnt_q <= 4'h0;
				end else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule // ivs_cpu_model

/* ivs_params.svh */
// Purpose: constants for the interrupt vector selector
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   program addresses are 24 bits wide
`ifndef IVS_PARAMS_SVH
`define IVS_PARAMS_SVH
`define IVS_OFF_CTRL2      8'h00
`define IVS_OFF_REQ0       8'h04
`define IVS_OFF_EN0        8'h08
`define IVS_OFF_PRIO0      8'h0C
`define IVS_OFF_VECSTAT    8'h10
`define IVS_OFF_IRQSTAT    8'h14
`define IVS_OFF_IRQMASK    8'h18
`define IVS_ALT_BIT        15
`define IVS_TRAP_BASE      24'h000004
`define IVS_IRQ_BASE       24'h000014
`define IVS_ALT_OFFSET     24'h000100
`define IVS_RESET_PC       24'h000000
`define IVS_NUM_TRAPS      8
`define IVS_NUM_SRC        16
`define IVS_PRIO_W         3
`endif

/* ivs_pkg.sv */
// Purpose: types for the interrupt vector selector
// Assumes: none
// Notes:   fetch request and answer travel as structs
package ivs_pkg;
	typedef logic [23:0] ivs_addr_t;
	typedef struct packed {
		logic       valid;
		logic       is_trap;
		logic [6:0] number;
	} ivs_fetch_req_s;
	typedef struct packed {
		logic      valid;
		logic      alt;
		ivs_addr_t addr;
	} ivs_fetch_rsp_s;
	typedef enum logic [0:0] {
		IVS_IDLE = 1'b0,
		IVS_HOLD = 1'b1
	} ivs_state_e;
endpackage

/* ivs_vector_selector.sv */
// Purpose: vector address generation with primary/alternate table select
// Assumes: one clock, synchronous active-low reset, AXI4-Lite slave
// Notes:   sixteen sources modelled (flag/enable register 0); only priority register 0 is writable, so sources 8..15 never win
`timescale 1ns/1ps
`include "ivs_params.svh"
module ivs_vector_selector #(
	parameter int NSRC = `IVS_NUM_SRC
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [NSRC-1:0]       src_event,
	input  wire ivs_pkg::ivs_fetch_req_s fetch_req,
	input  wire logic                  fetch_done,
	output ivs_pkg::ivs_fetch_rsp_s    fetch_rsp,
	output logic [23:0]                reset_pc,
	output logic                       irq
);
	logic        alt_q;
	logic [15:0] req_q, en_q, prio_q0, prio_q1, prio_q2, prio_q3;
	logic [1:0]  ist_q, imask_q;
	logic [6:0]  best_num_q;
	logic        best_valid_q;
	logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [1:0]  bresp_q, rresp_q;
	ivs_pkg::ivs_state_e state_q;
	ivs_pkg::ivs_fetch_rsp_s rsp_q;

	// Vector slot address for a trap or interrupt in the chosen table
	function automatic ivs_pkg::ivs_addr_t slot_addr(input logic trap, input logic [6:0] n,
		input logic alt);
		ivs_pkg::ivs_addr_t base;
		base = trap ? `IVS_TRAP_BASE : `IVS_IRQ_BASE;
		slot_addr = base + {16'h0000, n, 1'b0} + (alt ? `IVS_ALT_OFFSET : 24'h000000);
	endfunction

	// Priority field of source n
	function automatic logic [2:0] prio_of(input logic [3:0] n);
		logic [15:0] r;
		r = (n[3:2] == 2'h0) ? prio_q0 : (n[3:2] == 2'h1) ? prio_q1 :
		    (n[3:2] == 2'h2) ? prio_q2 : prio_q3;
		prio_of = r[{n[1:0], 2'b00} +: 3];
	endfunction

	wire wr_go = aw_held_q && w_held_q && !bvalid_q;
	wire rd_go = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign fetch_rsp     = rsp_q;
	// fetch begins at address zero after reset
	assign reset_pc      = `IVS_RESET_PC;
	assign irq           = |(ist_q & imask_q);

	wire [15:0] pend = req_q & en_q;
	wire wr_ctrl = wr_go && awaddr_q == `IVS_OFF_CTRL2;
	wire wr_req  = wr_go && awaddr_q == `IVS_OFF_REQ0;
	wire wr_en   = wr_go && awaddr_q == `IVS_OFF_EN0;
	wire wr_pr   = wr_go && awaddr_q[7:4] == 4'h0 && awaddr_q[3:2] == 2'h3;
	wire wr_ist  = wr_go && awaddr_q == `IVS_OFF_IRQSTAT;
	wire wr_msk  = wr_go && awaddr_q == `IVS_OFF_IRQMASK;
	wire wr_known = wr_ctrl || wr_req || wr_en || wr_pr || wr_ist || wr_msk ||
		(awaddr_q >= 8'h0C && awaddr_q <= 8'h18 && awaddr_q[1:0] == 2'h0);

	// Highest priority pending source; ties go to lower number
	logic [6:0] win_num;
	logic       win_valid;
	logic [2:0] win_prio;
	always_comb begin
		win_num = 7'h00;
		win_valid = 1'b0;
		win_prio = 3'h0;
		// strict greater keeps the lower vector on a tie
		for (int i = 0; i < NSRC; i++) begin
			if (pend[i] && prio_of(4'(i)) != 3'h0 && (!win_valid || prio_of(4'(i)) > win_prio)) begin
				win_valid = 1'b1;
				win_prio = prio_of(4'(i));
				win_num = 7'(i);
			end
		end
	end

	logic [31:0] rd_val;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == `IVS_OFF_CTRL2)
			rd_val = {16'h0000, alt_q, 15'h0000};
		else if (s_axi_araddr == `IVS_OFF_REQ0)
			rd_val = {16'h0000, req_q};
		else if (s_axi_araddr == `IVS_OFF_EN0)
			rd_val = {16'h0000, en_q};
		else if (s_axi_araddr == `IVS_OFF_PRIO0)
			rd_val = {prio_q1, prio_q0};
		else if (s_axi_araddr == `IVS_OFF_VECSTAT)
			rd_val = {prio_q3[7:0], prio_q2[7:0], 7'h00, best_valid_q, 1'b0, best_num_q};
		else if (s_axi_araddr == `IVS_OFF_IRQSTAT)
			rd_val = {30'h0, ist_q};
		else if (s_axi_araddr == `IVS_OFF_IRQMASK)
			rd_val = {30'h0, imask_q};
		else begin
			rd_val = 32'h00000000;
			rd_ok = 1'b0;
		end
	end

	wire fetch_start = fetch_req.valid && state_q == ivs_pkg::IVS_IDLE;
	wire new_best = win_valid && (!best_valid_q || win_num != best_num_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h00000000;
			rdata_q   <= 32'h00000000;
			bresp_q   <= 2'h0;
			rresp_q   <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_known ? 2'h0 : 2'h2;
			end else if (s_axi_bready)
				bvalid_q <= 1'b0;
			if (rd_go) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_val;
				rresp_q  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	// reset clears everything; no vector fetched by it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alt_q <= 1'b0;
			req_q <= 16'h0000;
			en_q  <= 16'h0000;
			prio_q0 <= 16'h0000;
			prio_q1 <= 16'h0000;
			prio_q2 <= 16'h0000;
			prio_q3 <= 16'h0000;
			ist_q <= 2'h0;
			imask_q <= 2'h0;
			best_num_q <= 7'h00;
			best_valid_q <= 1'b0;
			state_q <= ivs_pkg::IVS_IDLE;
			rsp_q <= '0;
		end else begin
			// selection changes only on a register write
			if (wr_ctrl && s_axi_wstrb[1])
				alt_q <= wdata_q[`IVS_ALT_BIT];
			if (wr_en) en_q <= wdata_q[15:0];
			// Events set flags; set wins over a software write
			req_q <= (wr_req ? wdata_q[15:0] : req_q) | src_event;
			if (wr_pr && awaddr_q == `IVS_OFF_PRIO0) begin
				prio_q0 <= wdata_q[15:0] & 16'h7777;
				prio_q1 <= wdata_q[31:16] & 16'h7777;
			end
			if (wr_msk) imask_q <= wdata_q[1:0];
			best_num_q <= win_num;
			best_valid_q <= win_valid;
			// Bit0 new winner, bit1 fetch served; write one clears, set wins
			ist_q <= (ist_q & ~(wr_ist ? wdata_q[1:0] : 2'h0)) |
				{fetch_start, new_best};
			case (state_q)
				ivs_pkg::IVS_IDLE: begin
					if (fetch_req.valid) begin
						// table latched when the fetch starts
						rsp_q.valid <= 1'b1;
						rsp_q.alt   <= alt_q;
						rsp_q.addr  <= slot_addr(fetch_req.is_trap, fetch_req.number, alt_q);
						state_q <= ivs_pkg::IVS_HOLD;
					end
				end
				ivs_pkg::IVS_HOLD: begin
					if (fetch_done) begin
						rsp_q.valid <= 1'b0;
						state_q <= ivs_pkg::IVS_IDLE;
					end
				end
				default: state_q <= ivs_pkg::IVS_IDLE;
			endcase
		end
	end

	sequence s_fetch_begin;
		fetch_start;
	endsequence
	sequence s_fetch_answer;
		fetch_rsp.valid && fetch_rsp.alt == $past(alt_q);
	endsequence
	// Expected slot built from the table bases on its own
	property p_alt_addr;
		@(posedge aclk) disable iff (!aresetn)
		s_fetch_begin |=> fetch_rsp.addr ==
			($past(fetch_req.is_trap) ? `IVS_TRAP_BASE : `IVS_IRQ_BASE) +
			24'($past(fetch_req.number)) * 24'h000002 +
			($past(alt_q) ? `IVS_ALT_OFFSET : 24'h000000);
	endproperty
	a_alt_addr: assert property (p_alt_addr) else $error("vector address wrong");
	property p_fetch_alt;
		@(posedge aclk) disable iff (!aresetn)
		s_fetch_begin |=> s_fetch_answer;
	endproperty
	a_fetch_alt: assert property (p_fetch_alt) else $error("table flag not latched");
	property p_alt_off;
		@(posedge aclk) disable iff (!aresetn)
		fetch_start && !fetch_req.is_trap && fetch_req.number == 7'h00 |=>
			fetch_rsp.addr == ($past(alt_q) ? 24'h000114 : 24'h000014);
	endproperty
	a_alt_off: assert property (p_alt_off) else $error("interrupt 0 slot wrong");
	property p_no_reset_fetch;
		@(posedge aclk) !aresetn |=> !fetch_rsp.valid;
	endproperty
	a_no_reset_fetch: assert property (p_no_reset_fetch) else $error("fetch after reset");
	property p_reset_clear;
		@(posedge aclk) !aresetn |=> !alt_q && req_q == 16'h0000 && reset_pc == 24'h000000;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
	property p_reset_irq;
		@(posedge aclk) !aresetn |=> !irq && ist_q == 2'h0;
	endproperty
	a_reset_irq: assert property (p_reset_irq) else $error("interrupt after reset");
	property p_trap_slot;
		@(posedge aclk) disable iff (!aresetn)
		fetch_start && fetch_req.is_trap && fetch_req.number == 7'h07 && !alt_q |=>
			fetch_rsp.addr == 24'h000012;
	endproperty
	a_trap_slot: assert property (p_trap_slot) else $error("trap 7 slot wrong");
	property p_timer_slot;
		@(posedge aclk) disable iff (!aresetn)
		fetch_start && !fetch_req.is_trap && fetch_req.number == 7'h03 && !alt_q |=>
			fetch_rsp.addr == 24'h00001A;
	endproperty
	a_timer_slot: assert property (p_timer_slot) else $error("timer slot wrong");
	property p_hold_table;
		@(posedge aclk) disable iff (!aresetn)
		fetch_rsp.valid && !fetch_done |=> $stable(fetch_rsp.alt) && $stable(fetch_rsp.addr);
	endproperty
	a_hold_table: assert property (p_hold_table) else $error("fetch table changed");
	property p_alt_write_only;
		@(posedge aclk) disable iff (!aresetn)
		!wr_ctrl |=> $stable(alt_q);
	endproperty
	a_alt_write_only: assert property (p_alt_write_only) else $error("select changed");
	property p_tie_low;
		@(posedge aclk) disable iff (!aresetn)
		pend[3] && pend[5] && pend[2:0] == 3'h0 && prio_q0[14:12] == prio_q1[6:4] &&
			prio_q0[14:12] != 3'h0 && prio_q0[14:12] >= win_prio |-> win_num == 7'h03;
	endproperty
	a_tie_low: assert property (p_tie_low) else $error("tie not to lower vector");
	property p_flag_bit;
		@(posedge aclk) disable iff (!aresetn)
		src_event[3] |=> req_q[3];
	endproperty
	a_flag_bit: assert property (p_flag_bit) else $error("flag bit lost");
endmodule // ivs_vector_selector
